// ### rtl/bdfr_regs.sv
`timescale 1ns/1ps
// Operation
// - ramp step time is a 3-bit field at bits 10:8 resetting to 010b, code 111 undefined.
// - short threshold is a 2-bit field at bits 7:6 resetting to 01b.
// - dimming frequency is a 4-bit field at bits 5:2 resetting to 1111b, code 0110 undefined.
// - the dimming frequency applies only in PWM or mixed dimming, not in pure analog.
// - frequency code 1111 with external mixed dimming (100b) follows the external PWM input.
// - mixed dimming uses analog above the transfer point and PWM at or below it.
// - the bus duty is 14 bits at 13:0, reset zero, 0x3FFF meaning full duty.
// - the bus duty steers current only for dimming modes 001b and 101b.
// - bits 15:8 of the status register hold a read-only identity code.
// - a read-only 3-bit burn count resets to zero and counts up once per burn.
// - five read-only fault flags at bits 4:0 reset to zero and read one on fault.
// - a fault flag stays latched with shutdown held until the host reads it.
// - an 8-bit full-scale current code sets string current 0 to 50 mA.
// - dimming mode 000/001 is analog ext/bus, 100/101 mixed ext/bus.
module bdfr_regs #(
  parameter logic [7:0] PART_IDENT = 8'h5A  // arbitrary identity value
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [2:0]  dim_mode_sel_i,
  input  wire logic [7:0]  full_scale_current_i,
  input  wire logic        ext_pwm_i,
  input  wire logic [13:0] ext_duty_i,
  input  wire logic        burn_done_i,
  input  wire logic [4:0]  fault_event_i,
  output logic      [2:0]  ramp_step_time_o,
  output logic      [1:0]  short_threshold_sel_o,
  output logic      [3:0]  dim_freq_sel_o,
  output logic             freq_valid_o,
  output logic             freq_follow_ext_o,
  output logic             ext_pwm_o,
  output logic             pwm_dimming_o,
  output logic             analog_dimming_o,
  output logic      [13:0] dim_duty_o,
  output logic      [7:0]  full_scale_current_o,
  output logic             ramp_valid_o,
  output logic             fault_shutdown_o
);

  typedef struct packed {
    logic [2:0]  ramp;
    logic [1:0]  short_thr;
    logic [3:0]  freq;
    logic [1:0]  xfer;
    logic [13:0] duty;
    logic [2:0]  burn;
    logic [4:0]  flt;
    logic [15:0] rdata;
    logic        pwm_dim;
    logic        ana_dim;
    logic        follow;
    logic [13:0] dim_duty;
    logic [7:0]  iset;
  } bdfr_state_type;

  bdfr_state_type s_q;
  bdfr_state_type s_d;

  logic        mix_mode;
  logic        bus_mode;
  logic [13:0] sel_duty;
  logic [13:0] xfer_level;
  logic        rd_status;

  // mode decode and duty selection
  always_comb begin
    mix_mode  = (dim_mode_sel_i == bdfr_pkg::MODE_MIX_EXT) ||
                (dim_mode_sel_i == bdfr_pkg::MODE_MIX_BUS);
    bus_mode  = (dim_mode_sel_i == bdfr_pkg::MODE_ANA_BUS) ||
                (dim_mode_sel_i == bdfr_pkg::MODE_MIX_BUS);
    sel_duty  = bus_mode ? s_q.duty : ext_duty_i;
    rd_status = reg_rd_i && (reg_addr_i == bdfr_pkg::ADDR_IDENT_FLT);
    case (s_q.xfer)
      2'h0:    xfer_level = bdfr_pkg::XFER_6P25;
      2'h1:    xfer_level = bdfr_pkg::XFER_12P5;
      2'h2:    xfer_level = bdfr_pkg::XFER_25;
      default: xfer_level = bdfr_pkg::XFER_50;
    endcase
  end

  // next state: register writes, reads, faults and dimming decisions
  always_comb begin
    s_d = s_q;
    if (reg_wr_i) begin
      if (reg_addr_i == bdfr_pkg::ADDR_SLOPE_FREQ) begin
        s_d.ramp      = reg_wdata_i[bdfr_pkg::RAMP_MSB:bdfr_pkg::RAMP_LSB];
        s_d.short_thr = reg_wdata_i[bdfr_pkg::SHORT_MSB:bdfr_pkg::SHORT_LSB];
        s_d.freq      = reg_wdata_i[bdfr_pkg::FREQ_MSB:bdfr_pkg::FREQ_LSB];
        s_d.xfer      = reg_wdata_i[bdfr_pkg::XFER_MSB:bdfr_pkg::XFER_LSB];
      end else if (reg_addr_i == bdfr_pkg::ADDR_BUS_DUTY) begin
        s_d.duty = reg_wdata_i[bdfr_pkg::DUTY_MSB:0];
      end
    end
    // read data; identity and fault register ignores writes
    s_d.rdata = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == bdfr_pkg::ADDR_SLOPE_FREQ) begin
        s_d.rdata = {5'h00, s_q.ramp, s_q.short_thr, s_q.freq, s_q.xfer};
      end else if (reg_addr_i == bdfr_pkg::ADDR_BUS_DUTY) begin
        s_d.rdata = {2'h0, s_q.duty};
      end else if (reg_addr_i == bdfr_pkg::ADDR_IDENT_FLT) begin
        s_d.rdata = {PART_IDENT, s_q.burn, s_q.flt};
      end
    end
    // burn counter
    if (burn_done_i) begin
      s_d.burn = s_q.burn + 3'h1;
    end
    // read clears flags, new events win over the clear
    s_d.flt = (rd_status ? bdfr_pkg::FLT_RST : s_q.flt) | fault_event_i;
    // dimming decision
    s_d.iset     = full_scale_current_i;
    s_d.dim_duty = sel_duty;
    s_d.follow   = (s_q.freq == bdfr_pkg::FREQ_FOLLOW) && !bus_mode && mix_mode;
    if (mix_mode) begin
      s_d.ana_dim = sel_duty > xfer_level;
      s_d.pwm_dim = !(sel_duty > xfer_level);
    end else begin
      s_d.ana_dim = 1'b1;
      s_d.pwm_dim = 1'b0;
    end
  end

  // state register with clock enable
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_q           <= '0;
      s_q.ramp      <= bdfr_pkg::RAMP_RST;
      s_q.short_thr <= bdfr_pkg::SHORT_RST;
      s_q.freq      <= bdfr_pkg::FREQ_RST;
      s_q.xfer      <= bdfr_pkg::XFER_RST;
      s_q.duty      <= bdfr_pkg::DUTY_RST;
      s_q.burn      <= bdfr_pkg::BURN_RST;
      s_q.flt       <= bdfr_pkg::FLT_RST;
      s_q.iset      <= bdfr_pkg::ISET_RST;
      s_q.ana_dim   <= 1'b1;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata_o           = s_q.rdata;
  assign ramp_step_time_o      = s_q.ramp;
  assign ramp_valid_o          = s_q.ramp != bdfr_pkg::RAMP_UNDEF;
  assign short_threshold_sel_o = s_q.short_thr;
  assign dim_freq_sel_o        = s_q.freq;
  assign freq_valid_o          = s_q.pwm_dim && (s_q.freq != bdfr_pkg::FREQ_UNDEF);
  assign freq_follow_ext_o     = s_q.follow;
  assign ext_pwm_o             = ext_pwm_i && s_q.follow && s_q.pwm_dim;
  assign pwm_dimming_o         = s_q.pwm_dim;
  assign analog_dimming_o      = s_q.ana_dim;
  assign dim_duty_o            = s_q.dim_duty;
  assign full_scale_current_o  = s_q.iset;
  assign fault_shutdown_o      = |s_q.flt;

  // status read strobe taken on this edge; shared by the read-clear checks
  sequence status_read_s;
    clk_en_i && rd_status;
  endsequence

  // assertions
  a_fault_latch_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && !rd_status |=> (s_q.flt & $past(s_q.flt)) == $past(s_q.flt))
    else $error("fault flag dropped without a read");
  a_fault_set_wins: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    status_read_s ##0 (fault_event_i != 5'h00)
    |=> (s_q.flt & $past(fault_event_i)) == $past(fault_event_i))
    else $error("fault arriving during read was lost");
  a_read_clears: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    status_read_s ##0 (fault_event_i == 5'h00) |=> s_q.flt == 5'h00)
    else $error("fault flags not cleared by read");
  a_ident_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && rd_status |=> reg_rdata_o[15:8] == PART_IDENT)
    else $error("identity code wrong");
  a_burn_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && burn_done_i |=> s_q.burn == $past(s_q.burn) + 3'h1)
    else $error("burn count did not step");
  a_duty_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && reg_wr_i && reg_addr_i == bdfr_pkg::ADDR_BUS_DUTY
    |=> s_q.duty == $past(reg_wdata_i[bdfr_pkg::DUTY_MSB:0]))
    else $error("bus duty not stored");
  a_slope_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && reg_wr_i && reg_addr_i == bdfr_pkg::ADDR_SLOPE_FREQ
    |=> ramp_step_time_o == $past(reg_wdata_i[bdfr_pkg::RAMP_MSB:bdfr_pkg::RAMP_LSB])
    && dim_freq_sel_o == $past(reg_wdata_i[bdfr_pkg::FREQ_MSB:bdfr_pkg::FREQ_LSB]))
    else $error("slope register not stored");
  a_analog_no_pwm: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && !mix_mode |=> !pwm_dimming_o && !freq_valid_o)
    else $error("pwm dimming active in analog mode");
  a_mix_split: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && mix_mode && bus_mode && s_q.duty <= xfer_level |=> pwm_dimming_o)
    else $error("mixed mode chose analog at or below transfer point");
  a_shutdown: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && fault_event_i != 5'h00 |=> fault_shutdown_o)
    else $error("shutdown not raised by a fault");
  a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero without a read");
  a_status_ro: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && reg_wr_i && reg_addr_i == bdfr_pkg::ADDR_IDENT_FLT
    |=> $stable(s_q.duty) && $stable(ramp_step_time_o) && $stable(dim_freq_sel_o))
    else $error("write to status register changed a field");
  a_follow_ext: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && s_q.freq == bdfr_pkg::FREQ_FOLLOW && dim_mode_sel_i == bdfr_pkg::MODE_MIX_EXT
    |=> freq_follow_ext_o)
    else $error("external rate not followed");
  a_bus_duty_sel: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && bus_mode |=> dim_duty_o == $past(s_q.duty))
    else $error("bus duty not applied in bus mode");
  a_iset_path: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i |=> full_scale_current_o == $past(full_scale_current_i))
    else $error("full-scale current code not passed on");

endmodule : bdfr_regs

// ### rtl/bdfr_pkg.sv
package bdfr_pkg;
  // register addresses on the two-wire bus
  localparam logic [7:0] ADDR_SLOPE_FREQ = 8'h03;
  localparam logic [7:0] ADDR_BUS_DUTY   = 8'h04;
  localparam logic [7:0] ADDR_IDENT_FLT  = 8'h05;
  // field positions, slope / threshold / frequency, bus duty and identity / fault registers
  localparam int RAMP_LSB   = 8;
  localparam int RAMP_MSB   = 10;
  localparam int SHORT_LSB  = 6;
  localparam int SHORT_MSB  = 7;
  localparam int FREQ_LSB   = 2;
  localparam int FREQ_MSB   = 5;
  localparam int XFER_LSB   = 0;
  localparam int XFER_MSB   = 1;
  localparam int DUTY_MSB   = 13;
  localparam int IDENT_LSB  = 8;
  localparam int BURN_LSB   = 5;
  localparam int FLT_LSB    = 0;
  // reset values
  localparam logic [2:0]  RAMP_RST  = 3'h2;
  localparam logic [1:0]  SHORT_RST = 2'h1;
  localparam logic [3:0]  FREQ_RST  = 4'hF;
  localparam logic [1:0]  XFER_RST  = 2'h2;
  localparam logic [13:0] DUTY_RST  = 14'h0000;
  localparam logic [7:0]  ISET_RST  = 8'h00;
  localparam logic [2:0]  BURN_RST  = 3'h0;
  localparam logic [4:0]  FLT_RST   = 5'h00;
  // field codes
  localparam logic [3:0]  FREQ_FOLLOW   = 4'hF;
  localparam logic [3:0]  FREQ_UNDEF    = 4'h6;
  localparam logic [2:0]  RAMP_UNDEF    = 3'h7;
  localparam logic [2:0]  MODE_ANA_EXT  = 3'h0;
  localparam logic [2:0]  MODE_ANA_BUS  = 3'h1;
  localparam logic [2:0]  MODE_MIX_EXT  = 3'h4;
  localparam logic [2:0]  MODE_MIX_BUS  = 3'h5;
  // transfer point thresholds on the 14-bit duty scale: 6.25/12.5/25/50 %
  localparam logic [13:0] XFER_6P25 = 14'h0400;
  localparam logic [13:0] XFER_12P5 = 14'h0800;
  localparam logic [13:0] XFER_25   = 14'h1000;
  localparam logic [13:0] XFER_50   = 14'h2000;
  localparam logic [13:0] DUTY_ZERO = 14'h0000;
endpackage : bdfr_pkg

// ### tb/bdfr_host.sv
`timescale 1ns/1ps
module bdfr_host (
  input  wire logic        clk_sys_i,
  output logic      [7:0]  reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // one-cycle write strobe; stale lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge clk_sys_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  endtask : wr
  // one-cycle read strobe; reading the identity and fault register acknowledges latched faults
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(negedge clk_sys_i);
    d = reg_rdata_i;
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
  endtask : rd
endmodule : bdfr_host

// ### tb/bdfr_regs_tb_top.sv
`timescale 1ns/1ps
module bdfr_regs_tb_top;
  localparam logic [7:0] IDENT = 8'hA7;  // arbitrary identity value
  logic        clk_sys_i, sys_rst_i, clk_en_i, wr, rd, ext_pwm_i, burn_done_i;
  logic        fq_ok, fol, epwm, pwm, ana, r_ok, shut;
  logic [7:0]  addr, fsc_i, fsc;
  logic [15:0] wdata, rdata, rv;
  logic [2:0]  mode, ramp;
  logic [1:0]  thr;
  logic [3:0]  fq;
  logic [13:0] ext_duty_i, duty, th;
  logic [4:0]  flt;
  int          n_fail = 0;
  int          samples_checked = 0;
  bdfr_host i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  bdfr_regs #(.PART_IDENT(IDENT)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .dim_mode_sel_i(mode), .full_scale_current_i(fsc_i),
    .ext_pwm_i(ext_pwm_i), .ext_duty_i(ext_duty_i), .burn_done_i(burn_done_i),
    .fault_event_i(flt), .ramp_step_time_o(ramp), .short_threshold_sel_o(thr),
    .dim_freq_sel_o(fq), .freq_valid_o(fq_ok), .freq_follow_ext_o(fol), .ext_pwm_o(epwm),
    .pwm_dimming_o(pwm), .analog_dimming_o(ana), .dim_duty_o(duty),
    .full_scale_current_o(fsc), .ramp_valid_o(r_ok), .fault_shutdown_o(shut));
  // compare one observed value with its expectation
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(negedge clk_sys_i);
  endtask : settle
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    results();
  end
  initial begin
    {sys_rst_i, clk_en_i, ext_pwm_i, burn_done_i} = 4'hC;
    {mode, fsc_i, ext_duty_i, flt} = '0;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    // reset image, read-only status and an unmapped hole
    i_host.rd(bdfr_pkg::ADDR_SLOPE_FREQ, rv);
    chk("reg03_rst", rv, 16'h027E);
    i_host.rd(bdfr_pkg::ADDR_BUS_DUTY, rv);
    chk("reg04_rst", rv, 16'h0000);
    i_host.wr(bdfr_pkg::ADDR_IDENT_FLT, 16'h00FF);
    i_host.rd(bdfr_pkg::ADDR_IDENT_FLT, rv);
    chk("reg05_ro", rv, {IDENT, 8'h00});
    i_host.wr(8'h07, 16'hFFFF);
    i_host.rd(8'h07, rv);
    chk("hole", rv, 16'h0000);
    // top codes, then the undefined frequency code, then frozen clock enable
    i_host.wr(bdfr_pkg::ADDR_SLOPE_FREQ, 16'hFFFF);
    i_host.rd(bdfr_pkg::ADDR_SLOPE_FREQ, rv);
    chk("reg03_all", rv, 16'h07FF);
    chk("fields", {5'h0, ramp, thr, fq, 1'b0, r_ok}, 16'h07FC);
    mode = bdfr_pkg::MODE_MIX_BUS;
    i_host.wr(bdfr_pkg::ADDR_SLOPE_FREQ, 16'h0618);
    settle();
    chk("undef_freq", {14'h0, r_ok, fq_ok}, 16'h0002);
    clk_en_i = 1'b0;
    i_host.wr(bdfr_pkg::ADDR_SLOPE_FREQ, 16'h0000);
    clk_en_i = 1'b1;
    i_host.rd(bdfr_pkg::ADDR_SLOPE_FREQ, rv);
    chk("frozen", rv, 16'h0618);
    // transfer point boundary for all four codes
    for (int k = 0; k < 4; k++) begin
      th = 14'h0400 << k;
      i_host.wr(bdfr_pkg::ADDR_SLOPE_FREQ, {10'h018, 4'h7, k[1:0]});
      i_host.wr(bdfr_pkg::ADDR_BUS_DUTY, {2'h0, th});
      settle();
      chk("at_point", {13'h0, fq_ok, pwm, ana}, 16'h0006);
      i_host.wr(bdfr_pkg::ADDR_BUS_DUTY, {2'h0, th + 14'h1});
      settle();
      chk("above", {14'h0, pwm, ana}, 16'h0001);
      chk("mix_duty", {2'h0, duty}, {2'h0, th + 14'h1});
    end
    // analog modes: external duty, then full bus duty
    {mode, ext_duty_i} = {bdfr_pkg::MODE_ANA_EXT, 14'h0123};
    settle();
    chk("ana_ext", {duty, pwm, ana}, {14'h0123, 2'h1});
    chk("ana_freq", {15'h0, fq_ok}, 16'h0000);
    mode = bdfr_pkg::MODE_ANA_BUS;
    i_host.wr(bdfr_pkg::ADDR_BUS_DUTY, 16'hFFFF);
    i_host.rd(bdfr_pkg::ADDR_BUS_DUTY, rv);
    chk("duty_full", rv, 16'h3FFF);
    settle();
    chk("ana_bus", {duty, pwm, ana}, {14'h3FFF, 2'h1});
    // follow the external input only with code 1111 and external mixed mode
    i_host.wr(bdfr_pkg::ADDR_SLOPE_FREQ, 16'h063F);
    {mode, ext_duty_i, ext_pwm_i, fsc_i} = {bdfr_pkg::MODE_MIX_EXT, 14'h0010, 1'b1, 8'hFF};
    settle();
    chk("follow", {6'h0, fsc, fol, epwm}, 16'h03FF);
    mode = bdfr_pkg::MODE_MIX_BUS;
    settle();
    chk("no_follow", {15'h0, fol}, 16'h0000);
    // three burns, then each fault latched and cleared by reading
    burn_done_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    burn_done_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      @(negedge clk_sys_i);
      flt = 5'h00;
      settle();
      chk("shut_on", {15'h0, shut}, 16'h0001);
      i_host.rd(bdfr_pkg::ADDR_IDENT_FLT, rv);
      chk("flag", rv, {IDENT, 3'h3, 5'h01 << i});
      i_host.rd(bdfr_pkg::ADDR_IDENT_FLT, rv);
      chk("cleared", rv, {IDENT, 3'h3, 5'h00});
      chk("shut_off", {15'h0, shut}, 16'h0000);
    end
    // fault arriving in the same cycle as the clearing read
    fork
      i_host.rd(bdfr_pkg::ADDR_IDENT_FLT, rv);
      begin
        @(negedge clk_sys_i);
        flt = 5'h10;
        @(negedge clk_sys_i);
        flt = 5'h00;
      end
    join
    chk("raced_read", rv, {IDENT, 3'h3, 5'h00});
    i_host.rd(bdfr_pkg::ADDR_IDENT_FLT, rv);
    chk("kept", rv, {IDENT, 3'h3, 5'h10});
    results();
  end
endmodule : bdfr_regs_tb_top
